// ===== rtl/rsc_pkg.sv
package rsc_pkg;
    // Clock and serial word.
    localparam int          CLK_PERIOD_NS = 25;
    localparam int          WORD_BITS     = 32;
    localparam logic [5:0]  WORD_BITS_CNT = 6'(WORD_BITS);
    localparam logic [5:0]  BIT_CNT_MAX   = 6'h3F;
    // Reset and factory content of the first configuration word.
    localparam logic [31:0] CFG_RESET     = 32'h002C0040;
    // Register offset in bits 7:4 and command codes in the low nibble of a word.
    localparam logic [3:0]  REG0_OFFSET   = 4'h0;
    localparam logic [3:0]  CMD_READ      = 4'hE;
    localparam logic [3:0]  CMD_NVM       = 4'hF;
    localparam int          CMD_LSB       = 0;
    localparam int          ADDR_LSB      = 4;
    // Field positions.
    localparam int          BUF_LSB       = 0;
    localparam int          PRI_BIT       = 2;
    localparam int          SEC_BIT       = 3;
    localparam int          DIV_SRC_BIT   = 4;
    localparam int          SEL_REG_BIT   = 5;
    localparam int          PFD_LSB       = 6;
    localparam int          RSVD_BIT      = 8;
    localparam int          CP_POL_BIT    = 9;
    // Buffer type codes.
    localparam logic [1:0]  BUF_CODE_LVCMOS = 2'h0;
    localparam logic [1:0]  BUF_CODE_LVPECL = 2'h2;
    localparam logic [1:0]  BUF_CODE_LVDS   = 2'h3;
    // Settling time before the stored word is copied in.
    localparam int          NVM_LOAD_TIME_NS = 1000;
    localparam logic [5:0]  NVM_LOAD_CYCLES  =
        6'((NVM_LOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [1:0] {RSC_REF_NONE, RSC_REF_PRI, RSC_REF_SEC} rsc_ref_e;
    typedef enum logic [1:0] {RSC_BUF_LVCMOS, RSC_BUF_UNDEF, RSC_BUF_LVPECL, RSC_BUF_LVDS} rsc_buf_e;

    // Maps the two-bit buffer type code onto a buffer kind.
    function automatic rsc_buf_e rsc_buf_kind(input logic [1:0] code);
        case (code)
            BUF_CODE_LVPECL: rsc_buf_kind = RSC_BUF_LVPECL;
            BUF_CODE_LVDS:   rsc_buf_kind = RSC_BUF_LVDS;
            BUF_CODE_LVCMOS: rsc_buf_kind = RSC_BUF_LVCMOS;
            default:         rsc_buf_kind = RSC_BUF_UNDEF;
        endcase
    endfunction : rsc_buf_kind
endpackage : rsc_pkg

// ===== rtl/rsc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rsc_link_if;
    logic        word_valid;
    logic [31:0] word_data;
    logic        le_high;
    logic        read_taken;
    logic        read_valid;
    logic [31:0] read_data;
    modport rx   (output word_valid, word_data, le_high, read_taken, input read_valid, read_data);
    modport core (input word_valid, word_data, le_high, read_taken, output read_valid, read_data);
endinterface : rsc_link_if
`default_nettype wire

// ===== rtl/rsc_serial.sv
`timescale 1ns/1ps
`default_nettype none
module rsc_serial
    import rsc_pkg::*;
(
    input  wire logic clk,               // System clock.
    input  wire logic reset_n,           // Synchronous reset, active low.
    input  wire logic serial_clk,        // Serial clock pin.
    input  wire logic serial_data_in,    // Serial data pin from host.
    input  wire logic latch_enable_line, // Frame pin, low during a word.
    output logic      serial_data_out,   // Serial read data to host.
    rsc_link_if.rx    lnk                // Words to the core.
);
    typedef struct packed {
        logic [2:0]  s1;
        logic [2:0]  s2;
        logic        sclk_d;
        logic        le_d;
        logic [31:0] shreg;
        logic [5:0]  cnt;
        logic        wv;
        logic [31:0] wdata;
        logic        taken;
        logic [31:0] txreg;
        logic        miso;
    } rsc_ser_s;

    rsc_ser_s r;
    rsc_ser_s n;
    logic     sclk_rise;
    logic     sclk_fall;
    logic     le_rise;
    logic     le_fall;

    // Edges are taken from the second stage only, never the first.
    assign sclk_rise = r.s2[2] & ~r.sclk_d;
    assign sclk_fall = ~r.s2[2] & r.sclk_d;
    assign le_rise   = r.s2[0] & ~r.le_d;
    assign le_fall   = ~r.s2[0] & r.le_d;

    // Shift in LSB first while the frame is low; close the word on frame rise.
    always_comb begin
        n        = r;
        n.s1     = {serial_clk, serial_data_in, latch_enable_line};
        n.s2     = r.s1;
        n.sclk_d = r.s2[2];
        n.le_d   = r.s2[0];
        n.wv     = 1'b0;
        n.taken  = 1'b0;
        if (le_fall) begin
            n.cnt   = '0;
            n.taken = lnk.read_valid;
            n.txreg = lnk.read_valid ? {lnk.read_data[31:1], 1'b0} : '0;
            n.miso  = 1'b0;
        end else if (sclk_fall && !r.s2[0]) begin
            n.txreg = r.txreg >> 1;
            n.miso  = r.txreg[1];
        end
        if (sclk_rise && !r.s2[0]) begin
            n.shreg = {r.s2[1], r.shreg[31:1]};
            n.cnt   = (r.cnt == BIT_CNT_MAX) ? r.cnt : r.cnt + 6'h1;
        end
        if (le_rise && r.cnt == WORD_BITS_CNT) begin
            n.wv    = 1'b1;
            n.wdata = r.shreg;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            r <= '{s1: 3'h1, s2: 3'h1, le_d: 1'b1, default: '0};
        end else begin
            r <= n;
        end
    end

    assign lnk.word_valid  = r.wv;
    assign lnk.word_data   = r.wdata;
    assign lnk.le_high     = r.s2[0];
    assign lnk.read_taken  = r.taken;
    assign serial_data_out = r.miso;

    AST_WORD_LEN: assert property (@(posedge clk) disable iff (!reset_n)
        r.wv |-> $past(le_rise) && $past(r.cnt) == WORD_BITS_CNT)
        else $error("Word accepted without exactly 32 bits.");
endmodule : rsc_serial
`default_nettype wire

// ===== rtl/rsc_nvm.sv
`timescale 1ns/1ps
`default_nettype none
module rsc_nvm
    import rsc_pkg::*;
(
    input  wire logic   clk,        // System clock.
    input  wire logic   reset_n,    // Synchronous reset, active low.
    input  wire logic   le_high,    // Synchronised frame line level.
    output logic        load_valid, // One-cycle copy strobe.
    output logic [31:0] load_word   // Stored word being copied.
);
    typedef enum logic [1:0] {NVM_WAIT_LE, NVM_COUNT, NVM_DONE} rsc_nvm_e;
    typedef struct packed {
        rsc_nvm_e    st;
        logic [5:0]  cnt;
        logic        lv;
        logic [31:0] word;
    } rsc_nvm_s;

    rsc_nvm_s r;
    rsc_nvm_s n;

    // The copy waits for the frame line high, as a low line corrupts it.
    always_comb begin
        n    = r;
        n.lv = 1'b0;
        case (r.st)
            NVM_WAIT_LE: if (le_high) n.st = NVM_COUNT;
            NVM_COUNT: begin
                n.cnt = r.cnt + 6'h1;
                if (r.cnt == NVM_LOAD_CYCLES - 6'h1) begin
                    n.st   = NVM_DONE;
                    n.lv   = 1'b1;
                    n.word = CFG_RESET;
                end
            end
            NVM_DONE: n.st = NVM_DONE;
            default:  n.st = NVM_WAIT_LE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            r <= '{st: NVM_WAIT_LE, default: '0};
        end else begin
            r <= n;
        end
    end

    assign load_valid = r.lv;
    assign load_word  = r.word;

    AST_NVM_ONCE: assert property (@(posedge clk) disable iff (!reset_n)
        r.lv |=> !r.lv && r.st == NVM_DONE)
        else $error("Stored word copied more than once.");
endmodule : rsc_nvm
`default_nettype wire

// ===== rtl/rsc_refsel.sv
`timescale 1ns/1ps
`default_nettype none
module rsc_refsel
    import rsc_pkg::*;
(
    input  wire logic   clk,                      // 40 MHz system clock.
    input  wire logic   reset_n,                  // Synchronous reset, active low.
    input  wire logic   serial_clk,               // Serial clock pin.
    input  wire logic   serial_data_in,           // Serial data from host.
    input  wire logic   latch_enable_line,        // Frame pin, low during a word.
    output logic        serial_data_out,          // Serial read data to host.
    input  wire logic   reference_select_pin,     // High picks primary in pin mode.
    input  wire logic   primary_present,          // Primary clock seen alive.
    input  wire logic   secondary_present,        // Secondary clock seen alive.
    output logic [31:0] first_config_word,        // Whole configuration word.
    output rsc_buf_e    buffer_kind,              // Decoded input buffer type.
    output logic        buffer_type_bit_x,        // Buffer type code bit 0.
    output logic        buffer_type_bit_y,        // Buffer type code bit 1.
    output rsc_ref_e    reference_choice,         // Reference feeding the loop.
    output logic        primary_reference_on,     // Primary buffer powered.
    output logic        secondary_reference_on,   // Secondary buffer powered.
    output logic        auto_select_active,       // Automatic selection running.
    output logic        divider_start_source,     // 1: VCXO or auxiliary clock.
    output logic [1:0]  detector_pulse_width,     // Detector pulse width code.
    output logic        pump_current_polarity,    // Charge pump direction.
    output logic        config_loaded             // Stored word has been copied.
);
    rsc_link_if lnk ();
    logic        load_valid;
    logic [31:0] load_word;

    // Serial engine for the host pins.
    rsc_serial u_serial (
        .clk               (clk),
        .reset_n           (reset_n),
        .serial_clk        (serial_clk),
        .serial_data_in    (serial_data_in),
        .latch_enable_line (latch_enable_line),
        .serial_data_out   (serial_data_out),
        .lnk               (lnk.rx)
    );

    // Power-up copy of the stored word.
    rsc_nvm u_nvm (
        .clk        (clk),
        .reset_n    (reset_n),
        .le_high    (lnk.le_high),
        .load_valid (load_valid),
        .load_word  (load_word)
    );

    typedef struct packed {
        logic [31:0] cfg;
        logic        loaded;
        logic        rd_pend;
        logic [31:0] rd_data;
        logic [2:0]  s1;
        logic [2:0]  s2;
        rsc_ref_e    sel;
        logic        pri_on;
        logic        sec_on;
        logic        auto_on;
    } rsc_core_s;

    rsc_core_s  r;
    rsc_core_s  n;
    logic [3:0] cmd;
    logic [3:0] rd_addr;
    logic       pin_sync;
    logic       pri_ok;
    logic       sec_ok;
    logic       by_reg;
    logic [1:0] pick;

    assign cmd      = lnk.word_data[CMD_LSB +: 4];
    assign rd_addr  = lnk.word_data[ADDR_LSB +: 4];
    assign pin_sync = r.s2[2];
    assign pri_ok   = r.s2[1];
    assign sec_ok   = r.s2[0];
    assign by_reg   = r.cfg[SEL_REG_BIT];
    assign pick     = {r.cfg[PRI_BIT], r.cfg[SEC_BIT]};

    // Word handling, power-up copy and reference selection.
    always_comb begin
        n    = r;
        n.s1 = {reference_select_pin, primary_present, secondary_present};
        n.s2 = r.s1;
        // Copy of the stored word; a serial write is held off until it is done.
        if (load_valid) begin
            n.cfg    = load_word;
            n.loaded = 1'b1;
        end
        // A consumed read clears the request; a new read command in the same cycle wins.
        if (lnk.read_taken) begin
            n.rd_pend = 1'b0;
        end
        if (lnk.word_valid) begin
            if (cmd == CMD_READ) begin
                n.rd_pend = 1'b1;
                n.rd_data = (rd_addr == REG0_OFFSET) ? r.cfg : '0;
            end else if (cmd != CMD_NVM && r.loaded) begin
                n.cfg           = lnk.word_data;
                n.cfg[RSVD_BIT] = 1'b0;
            end
        end
        // Reference choice.
        n.auto_on = 1'b0;
        if (by_reg) begin
            case (pick)
                2'b10:   n.sel = RSC_REF_PRI;
                2'b01:   n.sel = RSC_REF_SEC;
                2'b11: begin
                    n.auto_on = 1'b1;
                    n.sel     = (!pri_ok && sec_ok) ? RSC_REF_SEC : RSC_REF_PRI;
                end
                default: n.sel = RSC_REF_NONE;
            endcase
        end else begin
            n.sel = pin_sync ? RSC_REF_PRI : RSC_REF_SEC;
        end
        // In automatic mode both buffers stay powered so the fall-back is quick.
        n.pri_on = n.auto_on || n.sel == RSC_REF_PRI;
        n.sec_on = n.auto_on || n.sel == RSC_REF_SEC;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            r <= '{cfg: CFG_RESET, sel: RSC_REF_NONE, default: '0};
        end else begin
            r <= n;
        end
    end

    // The link reads the pending request as a level until it is taken.
    assign lnk.read_valid = r.rd_pend;
    assign lnk.read_data  = r.rd_data;

    // Configuration fields come straight from the register.
    assign first_config_word      = r.cfg;
    assign buffer_kind            = rsc_buf_kind(r.cfg[BUF_LSB +: 2]);
    assign buffer_type_bit_x      = r.cfg[BUF_LSB];
    assign buffer_type_bit_y      = r.cfg[BUF_LSB + 1];
    assign divider_start_source   = r.cfg[DIV_SRC_BIT];
    assign detector_pulse_width   = r.cfg[PFD_LSB +: 2];
    assign pump_current_polarity  = r.cfg[CP_POL_BIT];
    assign reference_choice       = r.sel;
    assign primary_reference_on   = r.pri_on;
    assign secondary_reference_on = r.sec_on;
    assign auto_select_active     = r.auto_on;
    assign config_loaded          = r.loaded;

    // Checks on the configuration path.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_BUF_LVPECL: assert property (
        r.cfg[BUF_LSB +: 2] == BUF_CODE_LVPECL |-> buffer_kind == RSC_BUF_LVPECL)
        else $error("Code 10 did not give LVPECL.");

    AST_BUF_LVCMOS: assert property (
        r.cfg[BUF_LSB +: 2] == BUF_CODE_LVCMOS |-> buffer_kind == RSC_BUF_LVCMOS)
        else $error("Code 00 did not give LVCMOS.");

    AST_SEL_NONE: assert property (
        by_reg && pick == 2'b00 |=> reference_choice == RSC_REF_NONE
            && !primary_reference_on && !secondary_reference_on)
        else $error("Code 00 left a reference buffer on.");

    AST_SEL_PRI: assert property (
        by_reg && pick == 2'b10 |=> reference_choice == RSC_REF_PRI && !secondary_reference_on)
        else $error("Code 10 did not select the primary reference.");

    AST_SEL_SEC: assert property (
        by_reg && pick == 2'b01 |=> reference_choice == RSC_REF_SEC && !primary_reference_on)
        else $error("Code 01 did not select the secondary reference.");

    AST_AUTO_FALLBACK: assert property (
        by_reg && pick == 2'b11 && !pri_ok && sec_ok
            |=> reference_choice == RSC_REF_SEC && auto_select_active)
        else $error("Automatic mode did not fall back to secondary.");

    AST_AUTO_PREFER: assert property (
        by_reg && pick == 2'b11 && pri_ok |=> reference_choice == RSC_REF_PRI)
        else $error("Automatic mode did not prefer primary.");

    AST_PIN_MODE: assert property (
        !by_reg |=> !auto_select_active
            && reference_choice == ($past(pin_sync) ? RSC_REF_PRI : RSC_REF_SEC))
        else $error("Pin mode did not follow the select pin.");

    AST_PIN_IGNORED: assert property (
        by_reg && $stable(by_reg) && $changed(pin_sync) && $stable(pick) && pick != 2'b11
            |=> $stable(reference_choice))
        else $error("Select pin changed the choice in register mode.");

    AST_RESET_VALUE: assert property (
        $past(!reset_n) |-> first_config_word == CFG_RESET && !config_loaded)
        else $error("Configuration word wrong after reset.");

    AST_COPY: assert property (
        load_valid |=> config_loaded && first_config_word == $past(load_word))
        else $error("Stored word was not copied in.");

    AST_RSVD_ZERO: assert property (
        config_loaded |-> !first_config_word[RSVD_BIT])
        else $error("Reserved bit 8 held a one.");

    AST_FIELDS: assert property (
        lnk.word_valid && r.loaded && cmd != CMD_READ && cmd != CMD_NVM && !load_valid
            |=> detector_pulse_width == $past(lnk.word_data[PFD_LSB +: 2])
            && pump_current_polarity == $past(lnk.word_data[CP_POL_BIT])
            && divider_start_source == $past(lnk.word_data[DIV_SRC_BIT]))
        else $error("Written fields did not reach the outputs.");

    // Further checks on decoding, selection, loading and reads.

    // The differential code must never fall back to the single-ended buffer.
    AST_BUF_LVDS: assert property (
        r.cfg[BUF_LSB +: 2] == BUF_CODE_LVDS |-> buffer_kind == RSC_BUF_LVDS)
        else $error("Code 11 did not give LVDS.");

    // The unused code is flagged so nothing downstream trusts it.
    AST_BUF_UNDEF: assert property (
        r.cfg[BUF_LSB +: 2] == 2'h1 |-> buffer_kind == RSC_BUF_UNDEF)
        else $error("Code 01 was not flagged as undefined.");

    // Automatic mode keeps both buffers powered so a fall-back needs no start-up.
    AST_AUTO_BOTH_ON: assert property (
        by_reg && pick == 2'b11
            |=> auto_select_active && primary_reference_on && secondary_reference_on)
        else $error("Automatic mode did not power both buffers.");

    // Only code 11 may start automatic selection in register mode.
    AST_REG_NO_AUTO: assert property (
        by_reg && pick != 2'b11 |=> !auto_select_active)
        else $error("Automatic selection ran without code 11.");

    // Pin mode powers exactly one buffer, the one the pin names.
    AST_PIN_ONE_BUF: assert property (
        !by_reg |=> primary_reference_on != secondary_reference_on)
        else $error("Pin mode did not power exactly one buffer.");

    // A chosen primary reference must have its buffer powered.
    AST_PRI_POWERED: assert property (
        reference_choice == RSC_REF_PRI |-> primary_reference_on)
        else $error("Primary chosen with its buffer off.");

    // A chosen secondary reference must have its buffer powered.
    AST_SEC_POWERED: assert property (
        reference_choice == RSC_REF_SEC |-> secondary_reference_on)
        else $error("Secondary chosen with its buffer off.");

    // The copy happens once per reset and is never undone.
    AST_LOADED_STAYS: assert property (
        config_loaded |=> config_loaded)
        else $error("Loaded flag dropped without reset.");

    // A host write racing the power-up copy would be overwritten, so it is refused.
    AST_WRITE_HELD_OFF: assert property (
        lnk.word_valid && !r.loaded && !load_valid |=> $stable(first_config_word))
        else $error("Word written before the stored copy.");

    // Stored-memory commands are not register content.
    AST_NVM_CMD_IGNORED: assert property (
        lnk.word_valid && cmd == CMD_NVM && !load_valid |=> $stable(first_config_word))
        else $error("Memory command changed the register.");

    // A read command queues the addressed word for the next frame.
    AST_READ_QUEUED: assert property (
        lnk.word_valid && cmd == CMD_READ |=> lnk.read_valid
            && lnk.read_data == (($past(rd_addr) == REG0_OFFSET) ? $past(r.cfg) : 32'h0))
        else $error("Read command did not queue the register.");

    // Once the read frame has taken the word the request is gone.
    AST_READ_CLEARED: assert property (
        lnk.read_taken && !(lnk.word_valid && cmd == CMD_READ) |=> !lnk.read_valid)
        else $error("Read request stayed after it was taken.");

    // Main scenarios.
    CV_AUTO_SEC: cover property (auto_select_active && reference_choice == RSC_REF_SEC);
    CV_READ:     cover property (lnk.read_taken);
    CV_WRITE:    cover property (lnk.word_valid && r.loaded && cmd == REG0_OFFSET);
    CV_LOADED:   cover property ($rose(config_loaded));
    CV_PIN_SEC:  cover property (!by_reg && reference_choice == RSC_REF_SEC);
endmodule : rsc_refsel
`default_nettype wire

// ===== verification/rsc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rsc_host_model
    import rsc_pkg::*;
(
    input  wire logic clk,               // System clock, paces the host.
    input  wire logic serial_data_out,   // Read data from the device.
    output logic      serial_clk,        // Serial clock, still outside frames.
    output logic      serial_data_in,    // Serial data to the device.
    output logic      latch_enable_line  // Frame line, low during a word.
);
    // Each serial phase lasts 8 clk, four times what the two-stage synchronisers need.
    localparam int HALF = 8;

    // The frame line idles high so the power-up copy can run.
    initial begin
        serial_clk        = 1'b0;
        serial_data_in    = 1'b0;
        latch_enable_line = 1'b1;
    end

    // Shifts n bits of w LSB first and samples read data on each rising edge.
    // The caller keeps bit 8 of every written word at zero.
    task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] q);
        q = '0;
        @(posedge clk);
        latch_enable_line <= 1'b0;
        for (int i = 0; i < n; i++) begin
            serial_data_in <= w[i]; // Data moves only while the clock is low.
            repeat (HALF) @(posedge clk);
            q[i] = serial_data_out;
            serial_clk <= 1'b1;
            repeat (HALF) @(posedge clk);
            serial_clk <= 1'b0;
        end
        repeat (HALF) @(posedge clk);
        latch_enable_line <= 1'b1; // Frame rise ends the word.
        serial_data_in    <= ~serial_data_in; // Released line must not look valid.
        repeat (12) @(posedge clk);
    endtask : xfer
endmodule : rsc_host_model
`default_nettype wire

// ===== verification/reference_select_config_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module reference_select_config_tb_top
    import rsc_pkg::*;
;
    logic        clk;
    logic        reset_n;
    logic        sclk;
    logic        sdi;
    logic        le;
    logic        sdo;
    logic        ref_pin;
    logic        pri_ok;
    logic        sec_ok;
    logic [31:0] word;
    rsc_buf_e    buffer_kind;
    logic        bx;
    logic        by;
    rsc_ref_e    reference_choice;
    logic        pri_on;
    logic        sec_on;
    logic        auto_on;
    logic        div_src;
    logic [1:0]  pfd_w;
    logic        cp_pol;
    logic        loaded;
    logic [31:0] q;
    int          err_count = 0;
    int          samples_checked = 0;
    // Table entries: word, then {buffer kind, choice, pri on, sec on, auto}.
    logic [31:0] wt [6] = '{32'h20, 32'h22, 32'h23, 32'h24, 32'h2A, 32'h2C};
    logic [6:0]  et [6] = '{7'h00, 7'h40, 7'h60, 7'h0C, 7'h52, 7'h0F};

    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    rsc_refsel u_dut (
        .clk(clk), .reset_n(reset_n), .serial_clk(sclk), .serial_data_in(sdi),
        .latch_enable_line(le), .serial_data_out(sdo), .reference_select_pin(ref_pin),
        .primary_present(pri_ok), .secondary_present(sec_ok), .first_config_word(word),
        .buffer_kind(buffer_kind), .buffer_type_bit_x(bx), .buffer_type_bit_y(by),
        .reference_choice(reference_choice), .primary_reference_on(pri_on),
        .secondary_reference_on(sec_on), .auto_select_active(auto_on),
        .divider_start_source(div_src), .detector_pulse_width(pfd_w),
        .pump_current_polarity(cp_pol), .config_loaded(loaded)
    );

    rsc_host_model u_host (
        .clk(clk), .serial_data_out(sdo), .serial_clk(sclk),
        .serial_data_in(sdi), .latch_enable_line(le)
    );

    // Compares one value and counts it.
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // Writes one word of n bits through the serial link.
    task automatic wr(input logic [31:0] w, input int n);
        u_host.xfer(w, n, q);
    endtask : wr

    // Moves the select pin and primary presence inputs and lets the synchronisers settle.
    task automatic pins(input logic p, input logic pr);
        @(posedge clk);
        ref_pin <= p;
        pri_ok  <= pr;
        repeat (8) @(posedge clk);
    endtask : pins

    // Prints the counts and the verdict, then stops.
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    // The whole run needs well under 15000 clk; this cuts a hang short.
    initial begin
        repeat (30000) @(posedge clk);
        err_count++;
        test_done();
    end

    initial begin
        reset_n = 1'b0;
        ref_pin = 1'b1;
        pri_ok  = 1'b1;
        sec_ok  = 1'b1;
        repeat (20) @(posedge clk);
        check(word, CFG_RESET, "word in reset");
        check(loaded, 1'b0, "loaded in reset");
        reset_n <= 1'b1;
        for (int n = 0; n < 200 && loaded !== 1'b1; n++) begin
            @(posedge clk);
        end
        repeat (4) @(posedge clk);
        check(loaded, 1'b1, "copy done");
        check(word, CFG_RESET, "copied word");
        check(reference_choice, RSC_REF_PRI, "default pin choice");
        check(pfd_w, 2'h1, "default pulse width");
        // Buffer codes and register selection codes, all under register control.
        for (int i = 0; i < 6; i++) begin
            wr(wt[i], WORD_BITS);
            pins(1'b0, 1'b1); // Pin drops low, against every register choice but that of 32'h2A, to show it is ignored.
            check(word, wt[i], "written word");
            check({by, bx}, wt[i][1:0], "type bits");
            check({buffer_kind, reference_choice, pri_on, sec_on, auto_on}, et[i], "decode");
            pins(1'b1, 1'b1);
        end
        // Automatic mode falls back when the primary clock is lost.
        pins(1'b1, 1'b0);
        check({reference_choice, auto_on}, {RSC_REF_SEC, 1'b1}, "auto fallback");
        pins(1'b1, 1'b1);
        // Pin mode with select bits clear still follows the pin.
        wr(32'h5A5AF2D0, WORD_BITS);
        check({div_src, pfd_w, cp_pol}, 4'hF, "fields set");
        check({reference_choice, pri_on, sec_on, auto_on}, 5'h0C, "pin primary");
        pins(1'b0, 1'b1);
        check({reference_choice, pri_on, sec_on, auto_on}, 5'h12, "pin secondary");
        wr(32'h00000080, WORD_BITS);
        check({div_src, pfd_w, cp_pol}, 4'h4, "fields cleared");
        // Short words and stored-memory commands leave the register alone.
        wr(32'h00000020, WORD_BITS - 1);
        check(word, 32'h00000080, "short word");
        wr(32'h0000000F, WORD_BITS);
        check(word, 32'h00000080, "memory command");
        // Read back: command frame, then a frame that repeats the command.
        wr(32'h5A5AF2D0, WORD_BITS);
        wr({24'h0, REG0_OFFSET, CMD_READ}, WORD_BITS);
        u_host.xfer({24'h0, REG0_OFFSET, CMD_READ}, WORD_BITS, q);
        check(q, 32'h5A5AF2D0, "read back");
        test_done();
    end
endmodule : reference_select_config_tb_top
`default_nettype wire
